// file: pdlm_defines.vh
// offsets, field positions, reset values and timing for the phy management register bank
`ifndef PDLM_DEFINES_VH
`define PDLM_DEFINES_VH

// management register addresses
`define PDLM_ADDR_DIAG 5'h12
`define PDLM_ADDR_GAIN 5'h13
`define PDLM_ADDR_LEDCFG 5'h17
`define PDLM_ADDR_XOVER 5'h18

// reset values
`define PDLM_RST_DIAG 16'h0000
`define PDLM_RST_GAIN 16'h4000
`define PDLM_RST_LEDCFG 16'h0010
`define PDLM_RST_XOVER 16'h00c0

// diagnostic register bit positions
`define PDLM_DIAG_NEGF_BIT 12
`define PDLM_DIAG_DUPLEX_BIT 11
`define PDLM_DIAG_RATE_BIT 10
`define PDLM_DIAG_RXSIG_BIT 9
`define PDLM_DIAG_LOCK_BIT 8

// indicator config fields
`define PDLM_LED_SECOND_MSB 7
`define PDLM_LED_SECOND_LSB 4
`define PDLM_LED_FIRST_MSB 3
`define PDLM_LED_FIRST_LSB 0
`define PDLM_LEDCFG_USED_MSB 7

// indicator source codes
`define PDLM_SRC_LINK 4'h0
`define PDLM_SRC_ACT 4'h1
`define PDLM_SRC_100 4'h5
`define PDLM_SRC_10 4'h6
`define PDLM_SRC_FDX 4'h7
`define PDLM_SRC_LINK_BLINK 4'h8

// blink half period, 50 ms at 100 mhz
`define PDLM_BLINK_CYCLES 23'h4c4b40
`define PDLM_BLINK_CNT_W 23

`endif

// file: pdlm_led_select.v
// indicator source selector for one link indicator
`timescale 1ns/10ps
`include "pdlm_defines.vh"

module pdlm_led_select (
  input wire [3:0] i_code,     // source select code
  input wire i_link_ok,        // link up
  input wire i_activity,       // rx or tx activity
  input wire i_speed_100,      // 100base-tx resolved
  input wire i_full_duplex,    // full duplex resolved
  input wire i_blink_phase,    // free running blink phase
  output reg o_led             // selected indicator level
);

  // decode source code; reserved codes keep the indicator off
  always @* begin
    case (i_code)
      `PDLM_SRC_LINK: o_led = i_link_ok;
      `PDLM_SRC_ACT: o_led = i_activity;
      `PDLM_SRC_100: o_led = i_link_ok & i_speed_100;
      `PDLM_SRC_10: o_led = i_link_ok & ~i_speed_100;
      `PDLM_SRC_FDX: o_led = i_full_duplex;
      `PDLM_SRC_LINK_BLINK: o_led = i_link_ok & ~(i_activity & i_blink_phase);
      default: o_led = 1'b0;
    endcase
  end

endmodule

// file: pdlm_mac_model.sv
// management controller model issuing single word accesses
`timescale 1ns/10ps
module pdlm_mac_model (
  input wire i_clk,              // system clock
  input wire i_ack,              // access done
  input wire [15:0] i_rdata,     // read data
  output reg [4:0] o_addr,       // address
  output reg o_wr,               // write strobe
  output reg o_rd,               // read strobe
  output reg [15:0] o_wdata      // write data
);
  reg [15:0] ack_miss;
  initial begin
    ack_miss = 16'h0000;
    o_addr = 5'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // one cycle strobe; address and data stay until the ack edge, a missing ack is counted
  task wr16(input [4:0] a, input [15:0] d);
    begin
      @(posedge i_clk) {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
      @(posedge i_clk) o_wr <= 1'b0;
      @(posedge i_clk);
      if (i_ack !== 1'b1) ack_miss = ack_miss + 16'h0001;
    end
  endtask
  // read data taken at the edge where ack is seen; unknown if ack missing
  task rd16(input [4:0] a, output [15:0] d);
    begin
      @(posedge i_clk) {o_rd, o_addr, o_wdata} <= {1'b1, a, ~o_wdata};
      @(posedge i_clk) o_rd <= 1'b0;
      @(posedge i_clk);
      d = (i_ack === 1'b1) ? i_rdata : 16'hxxxx;
    end
  endtask
endmodule

// file: pdlm_phy_diag_led_mgmt_regs.v
// phy diagnostic, gain, indicator and crossover management registers
// Function
// - negotiation failure flag sticky, cleared by read
// - bit 11 shows full duplex result
// - bit 10 shows 100base-tx rate result
// - bit 9 shows receive signal detected
// - bit 8 shows receive pll locked
// - diagnostic at 0x12, reset zero, reserved zero
// - gain control at 0x13, reset 0x4000
// - indicator config at 0x17, upper byte zero
// - bits 7:4 select second indicator source
// - bits 3:0 select first indicator source
// - crossover control at 0x18, reset 0x00c0
// - management controller reads all registers, writes gain, indicator config and crossover; diagnostic is read only
`timescale 1ns/10ps
`include "pdlm_defines.vh"

module pdlm_phy_diag_led_mgmt_regs #(
  parameter [`PDLM_BLINK_CNT_W-1:0] P_BLINK_CYCLES = `PDLM_BLINK_CYCLES // blink half period
) (
  input wire i_clk,              // system clock, 100 mhz
  input wire i_rst,              // async reset, active high
  input wire [4:0] i_mgmt_addr,  // management register address
  input wire i_mgmt_wr,          // write strobe, one cycle
  input wire i_mgmt_rd,          // read strobe, one cycle
  input wire [15:0] i_mgmt_wdata, // write data
  output reg [15:0] o_mgmt_rdata, // read data, valid with ack
  output reg o_mgmt_ack,         // access done pulse
  input wire i_neg_fail,         // negotiation found no common technology
  input wire i_neg_full_duplex,  // negotiated full duplex
  input wire i_neg_speed_100,    // negotiated 100base-tx
  input wire i_rx_signal,        // receive signal or manchester data seen
  input wire i_rx_pll_lock,      // receive pll locked
  input wire i_link_ok,          // link up
  input wire i_activity,         // rx or tx activity
  output reg o_led_first,        // first indicator
  output reg o_led_second,       // second indicator
  output wire [15:0] o_tx_gain_ctl, // transmit gain control value
  output wire [15:0] o_xover_ctl // crossover mux control value
);

  localparam NSYNC = 7;
  // full reset word, only the low byte is stored
  localparam [15:0] LEDCFG_RST = `PDLM_RST_LEDCFG;

  // three-stage synchronisers on analog-side status pins
  wire [NSYNC-1:0] pin_in;
  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  reg [NSYNC-1:0] sync3_q;
  reg [NSYNC-1:0] filt_q;

  assign pin_in = {i_activity, i_link_ok, i_rx_pll_lock, i_rx_signal,
                   i_neg_speed_100, i_neg_full_duplex, i_neg_fail};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      // a change is accepted once stages two and three agree
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          filt_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            filt_q[g] <= sync3_q[g];
          end
        end
      end
    end
  endgenerate

  wire neg_fail_s = filt_q[0];
  wire full_duplex_s = filt_q[1];
  wire speed_100_s = filt_q[2];
  wire rx_signal_s = filt_q[3];
  wire pll_lock_s = filt_q[4];
  wire link_ok_s = filt_q[5];
  wire activity_s = filt_q[6];

  // address match decode, shared by read and write paths
  function is_addr;
    input [4:0] addr;
    input [4:0] match;
    begin
      is_addr = (addr == match);
    end
  endfunction

  wire rd_diag = i_mgmt_rd & is_addr(i_mgmt_addr, `PDLM_ADDR_DIAG);

  // negotiation failure edge detect
  reg neg_fail_prev_q;
  wire neg_fail_rise = neg_fail_s & ~neg_fail_prev_q;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      neg_fail_prev_q <= 1'b0;
    end else begin
      neg_fail_prev_q <= neg_fail_s;
    end
  end

  // sticky failure flag; a new failure wins over the read clear
  reg negotiation_failed_flag_q;
  reg negotiation_failed_flag_d;

  always @* begin
    negotiation_failed_flag_d = negotiation_failed_flag_q;
    if (rd_diag) begin
      negotiation_failed_flag_d = 1'b0;
    end
    if (neg_fail_rise) begin
      negotiation_failed_flag_d = 1'b1;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      negotiation_failed_flag_q <= 1'b0;
    end else begin
      negotiation_failed_flag_q <= negotiation_failed_flag_d;
    end
  end

  // diagnostic word, reserved bits zero
  reg [15:0] diag_word;

  always @* begin
    diag_word = `PDLM_RST_DIAG;
    diag_word[`PDLM_DIAG_NEGF_BIT] = negotiation_failed_flag_q;
    diag_word[`PDLM_DIAG_DUPLEX_BIT] = full_duplex_s;
    diag_word[`PDLM_DIAG_RATE_BIT] = speed_100_s;
    diag_word[`PDLM_DIAG_LOCK_BIT] = pll_lock_s;
    diag_word[`PDLM_DIAG_RXSIG_BIT] = rx_signal_s;
  end

  // writable registers
  reg [15:0] transceiver_gain_control_q;
  reg [7:0] indicator_source_config_q;
  reg [15:0] crossover_mux_control_q;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      transceiver_gain_control_q <= `PDLM_RST_GAIN;
      indicator_source_config_q <= LEDCFG_RST[7:0];
      crossover_mux_control_q <= `PDLM_RST_XOVER;
    end else if (i_mgmt_wr) begin
      if (is_addr(i_mgmt_addr, `PDLM_ADDR_GAIN)) begin
        transceiver_gain_control_q <= i_mgmt_wdata;
      end
      if (is_addr(i_mgmt_addr, `PDLM_ADDR_LEDCFG)) begin
        indicator_source_config_q <= i_mgmt_wdata[`PDLM_LEDCFG_USED_MSB:0];
      end
      if (is_addr(i_mgmt_addr, `PDLM_ADDR_XOVER)) begin
        crossover_mux_control_q <= i_mgmt_wdata;
      end
    end
  end

  assign o_tx_gain_ctl = transceiver_gain_control_q;
  assign o_xover_ctl = crossover_mux_control_q;

  // read mux; unmapped addresses read zero
  reg [15:0] rd_word;

  always @* begin
    case (i_mgmt_addr)
      `PDLM_ADDR_DIAG: rd_word = diag_word;
      `PDLM_ADDR_GAIN: rd_word = transceiver_gain_control_q;
      `PDLM_ADDR_LEDCFG: rd_word = {8'h00, indicator_source_config_q};
      `PDLM_ADDR_XOVER: rd_word = crossover_mux_control_q;
      default: rd_word = 16'h0000;
    endcase
  end

  // answer one cycle after each strobe; write data never reaches diag
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mgmt_rdata <= 16'h0000;
      o_mgmt_ack <= 1'b0;
    end else begin
      o_mgmt_ack <= i_mgmt_rd | i_mgmt_wr;
      if (i_mgmt_rd) begin
        o_mgmt_rdata <= rd_word;
      end
    end
  end

  // blink phase generator for link-with-activity mode
  reg [`PDLM_BLINK_CNT_W-1:0] blink_cnt_q;
  reg blink_phase_q;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      blink_cnt_q <= {`PDLM_BLINK_CNT_W{1'b0}};
      blink_phase_q <= 1'b0;
    end else if (blink_cnt_q >= P_BLINK_CYCLES - 1'b1) begin
      blink_cnt_q <= {`PDLM_BLINK_CNT_W{1'b0}};
      blink_phase_q <= ~blink_phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // indicator source selection
  wire led_first_sel;
  wire led_second_sel;

  pdlm_led_select u_first (
    .i_code(indicator_source_config_q[`PDLM_LED_FIRST_MSB:`PDLM_LED_FIRST_LSB]),
    .i_link_ok(link_ok_s),
    .i_activity(activity_s),
    .i_speed_100(speed_100_s),
    .i_full_duplex(full_duplex_s),
    .i_blink_phase(blink_phase_q),
    .o_led(led_first_sel)
  );

  pdlm_led_select u_second (
    .i_code(indicator_source_config_q[`PDLM_LED_SECOND_MSB:`PDLM_LED_SECOND_LSB]),
    .i_link_ok(link_ok_s),
    .i_activity(activity_s),
    .i_speed_100(speed_100_s),
    .i_full_duplex(full_duplex_s),
    .i_blink_phase(blink_phase_q),
    .o_led(led_second_sel)
  );

  // registered indicator outputs
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_led_first <= 1'b0;
      o_led_second <= 1'b0;
    end else begin
      o_led_first <= led_first_sel;
      o_led_second <= led_second_sel;
    end
  end

endmodule

// file: pdlm_phy_diag_led_mgmt_regs_tb_top.sv
// testbench for the phy management register bank
`timescale 1ns/10ps
module pdlm_phy_diag_led_mgmt_regs_tb_top;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [4:0] st = 5'h00;
  reg link = 1'b0;
  reg act = 1'b0;
  wire [4:0] addr;
  wire wr, rd, ack, led_fst, led_snd;
  wire [15:0] wdata, rdata, gain, xover;
  integer err_total = 0;
  integer n_tests = 0;
  always #5 i_clk = ~i_clk;
  pdlm_phy_diag_led_mgmt_regs #(.P_BLINK_CYCLES(23'h4)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_mgmt_addr(addr), .i_mgmt_wr(wr), .i_mgmt_rd(rd), .i_mgmt_wdata(wdata),
    .o_mgmt_rdata(rdata), .o_mgmt_ack(ack), .i_neg_fail(st[4]), .i_neg_full_duplex(st[3]),
    .i_neg_speed_100(st[2]), .i_rx_signal(st[1]), .i_rx_pll_lock(st[0]), .i_link_ok(link),
    .i_activity(act), .o_led_first(led_fst), .o_led_second(led_snd), .o_tx_gain_ctl(gain),
    .o_xover_ctl(xover));
  pdlm_mac_model i_mac (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [4:0] a, input [15:0] e);
    reg [15:0] d;
    begin
      i_mac.rd16(a, d);
      chk16(d, e);
    end
  endtask
  // status pins change, then wait past the sync filter
  task set_st(input [4:0] v);
    begin
      @(posedge i_clk) st <= v;
      repeat (6) @(posedge i_clk);
    end
  endtask
  task t_reset;
    begin
      rdchk(5'h12, 16'h0000);
      rdchk(5'h13, 16'h4000);
      rdchk(5'h17, 16'h0010);
      rdchk(5'h18, 16'h00c0);
      chk16(gain, 16'h4000);
      chk16(xover, 16'h00c0);
      chk16({14'h0, led_fst, led_snd}, 16'h0000);
    end
  endtask
  task t_rw;
    begin
      i_mac.wr16(5'h13, 16'ha5c3);
      chk16(gain, 16'ha5c3);
      rdchk(5'h13, 16'ha5c3);
      i_mac.wr16(5'h18, 16'h5a3c);
      rdchk(5'h18, 16'h5a3c);
      chk16(xover, 16'h5a3c);
      i_mac.wr16(5'h12, 16'hffff);
      rdchk(5'h12, 16'h0000);
      i_mac.wr16(5'h17, 16'hffff);
      rdchk(5'h17, 16'h00ff);
      i_mac.wr16(5'h1f, 16'h1234);
      rdchk(5'h1f, 16'h0000);
      chk16(i_mac.ack_miss, 16'h0000);
    end
  endtask
  task t_diag;
    begin
      set_st(5'b01010);
      rdchk(5'h12, 16'h0a00);
      set_st(5'b00101);
      rdchk(5'h12, 16'h0500);
      set_st(5'b10000);
      rdchk(5'h12, 16'h1000);
      rdchk(5'h12, 16'h0000);
      set_st(5'b00100);
    end
  endtask
  // one code per indicator, levels looked at away from the clock edge
  task led_case(input [3:0] c1, input [3:0] c2, input e1, input e2);
    begin
      i_mac.wr16(5'h17, {8'h00, c2, c1});
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk16({14'h0, led_fst, led_snd}, {14'h0, e1, e2});
    end
  endtask
  // codes on both indicators: link up, idle, 100 half, then active, 10 full
  task t_led;
    reg [7:0] na;
    reg [7:0] nb;
    integer k;
    begin
      @(posedge i_clk) link <= 1'b1;
      repeat (6) @(posedge i_clk);
      led_case(4'h0, 4'h1, 1'b1, 1'b0);
      led_case(4'h2, 4'h5, 1'b0, 1'b1);
      led_case(4'h6, 4'h7, 1'b0, 1'b0);
      led_case(4'h8, 4'h0, 1'b1, 1'b1);
      @(posedge i_clk) act <= 1'b1;
      set_st(5'b01000);
      led_case(4'h1, 4'h6, 1'b1, 1'b1);
      led_case(4'h7, 4'h5, 1'b1, 1'b0);
      led_case(4'h3, 4'h4, 1'b0, 1'b0);
      // blink with activity: four cycles of each phase in any eight
      i_mac.wr16(5'h17, 16'h0088);
      repeat (4) @(posedge i_clk);
      na = 8'h00;
      nb = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        @(negedge i_clk);
        na = na + {7'h00, led_fst};
        nb = nb + {7'h00, led_snd};
      end
      chk16({na, nb}, 16'h0404);
      chk16(i_mac.ack_miss, 16'h0000);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_rw;
    t_diag;
    t_led;
    final_report;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    final_report;
  end
endmodule

// file: pdlm_regs_asserts.sv
// port assertions for the phy management register bank
`timescale 1ns/10ps
module pdlm_regs_chk (
  input wire i_clk,              // system clock
  input wire i_rst,              // async reset
  input wire [4:0] i_mgmt_addr,  // address
  input wire i_mgmt_wr,          // write strobe
  input wire i_mgmt_rd,          // read strobe
  input wire [15:0] i_mgmt_wdata, // write data
  input wire [15:0] o_mgmt_rdata, // read data
  input wire o_mgmt_ack,         // access done
  input wire [15:0] o_tx_gain_ctl, // gain value
  input wire [15:0] o_xover_ctl  // crossover value
);
  wire acc = i_mgmt_rd | i_mgmt_wr;
  // address decode for the four mapped registers
  wire mapped = (i_mgmt_addr == 5'h12) || (i_mgmt_addr == 5'h13) ||
                (i_mgmt_addr == 5'h17) || (i_mgmt_addr == 5'h18);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ack_after_req: assert property (acc |=> o_mgmt_ack)
    else $error("no ack after access");
  a_no_stray_ack: assert property (!acc |=> !o_mgmt_ack)
    else $error("ack without access");
  a_rdata_hold: assert property (!i_mgmt_rd |=> $stable(o_mgmt_rdata))
    else $error("read data moved without read");
  a_diag_reserved: assert property (i_mgmt_rd && i_mgmt_addr == 5'h12
    |=> o_mgmt_rdata[15:13] == 3'h0 && o_mgmt_rdata[7:0] == 8'h00)
    else $error("diag reserved bits set");
  a_led_upper_zero: assert property (i_mgmt_rd && i_mgmt_addr == 5'h17
    |=> o_mgmt_rdata[15:8] == 8'h00)
    else $error("indicator config upper byte set");
  a_unmapped_zero: assert property (i_mgmt_rd && !i_mgmt_wr && !mapped
    |=> o_mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_gain_write: assert property (i_mgmt_wr && i_mgmt_addr == 5'h13
    |=> o_tx_gain_ctl == $past(i_mgmt_wdata))
    else $error("gain write lost");
  a_xover_write: assert property (i_mgmt_wr && i_mgmt_addr == 5'h18
    |=> o_xover_ctl == $past(i_mgmt_wdata))
    else $error("crossover write lost");
  a_gain_kept: assert property (!(i_mgmt_wr && i_mgmt_addr == 5'h13)
    |=> $stable(o_tx_gain_ctl))
    else $error("gain changed without write");
  c_diag_read: cover property (i_mgmt_rd && i_mgmt_addr == 5'h12);
  c_gain_write: cover property (i_mgmt_wr && i_mgmt_addr == 5'h13);
  c_unmapped: cover property (i_mgmt_rd && !mapped);
endmodule

bind pdlm_phy_diag_led_mgmt_regs pdlm_regs_chk i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_mgmt_addr(i_mgmt_addr), .i_mgmt_wr(i_mgmt_wr),
  .i_mgmt_rd(i_mgmt_rd), .i_mgmt_wdata(i_mgmt_wdata), .o_mgmt_rdata(o_mgmt_rdata),
  .o_mgmt_ack(o_mgmt_ack), .o_tx_gain_ctl(o_tx_gain_ctl), .o_xover_ctl(o_xover_ctl));
